//--- design/tfc_ctrl_regs.sv
// Framer receive and transmit control register bank with its control effects
// Contract
// RULE_01 - Auto resync select clear: resync on out-of-frame or carrier loss.
// RULE_02 - Select bit A clear: loss of frame at two of four framing bits bad; code uses a six-bit window whenever select bit B is set.
// RULE_03 - D4, criteria clear: find terminal pattern first, then signalling pattern.
// RULE_04 - D4, criteria set: search terminal and signalling patterns cross-coupled.
// RULE_05 - Fallback set and line clock stopped: use receive clock; clear never switches.
// RULE_06 - Framing pass-through: clear internal framing bits, set take serial input.
// RULE_07 - CRC pass-through: set take serial input, clear insert computed CRC6.
// RULE_08 - Robbed signalling enable inserts per channel unless transparent; clear none.
// RULE_09 - Global stuffing set stuffs all zero channels; clear transparency decides.
// RULE_10 - Link source select: clear link data register, set external link pin.
// RULE_11 - Blue alarm set sends unframed all ones on both line outputs.
// RULE_12 - Yellow alarm bit set sends yellow alarm; clear sends none.
// RULE_13 - Yellow form: clear bit 2 zero, set signalling bit one in frame 12.
// RULE_14 - Sync pulse mode: clear frame boundaries, set multiframe boundaries.
// RULE_15 - Test code: 00 normal, 01 high-Z, 10 low, 11 high except port.
// RULE_16 - Resync bit rising edge starts exactly one forced resync.
// RULE_17 - Every control bit reads back the value last written by the host.
module tfc_ctrl_regs #(
  parameter int CLK_LOSS_CYCLES = tfc_pkg::CLK_LOSS_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       rst_b_i,
  input  wire logic       cs_b_i,
  input  wire logic       rd_b_i,
  input  wire logic       wr_b_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] data_i,
  output logic      [7:0] data_o,
  output logic            data_oe_o,
  input  wire logic       oof_event_i,
  input  wire logic       carrier_loss_i,
  input  wire logic       fbit_valid_i,
  input  wire logic       fbit_error_i,
  output logic            resync_start_o,
  output logic            loss_of_frame_o,
  output logic            sync_cross_couple_o,
  output logic            sync_time_long_o,
  input  wire logic       tx_line_clock,
  output logic            tx_use_rx_clock_o,
  input  wire logic       tx_serial_in,
  input  wire logic       ext_link_pin_i,
  input  wire logic       fbit_time_i,
  input  wire logic       int_framing_bit_i,
  input  wire logic       int_crc_bit_i,
  input  wire logic       link_reg_bit_i,
  output logic            framing_bit_o,
  output logic            crc_bit_o,
  output logic            link_bit_o,
  input  wire logic       chan_transparent_i,
  input  wire logic       chan_all_zero_i,
  output logic            chan_sig_insert_o,
  output logic            chan_bit7_stuff_o,
  output logic            yellow_bit2_zero_o,
  input  wire logic [3:0] frame_number_i,
  output logic            yellow_sbit_one_o,
  input  wire logic       frame_start_i,
  input  wire logic       multiframe_start_i,
  input  wire logic       data_pos_i,
  input  wire logic       data_neg_i,
  output logic            tx_line_positive_out,
  output logic            tx_line_negative_out,
  output logic            tx_sync_pulse,
  output logic            line_oe_o
);
  // ==========================================================
  // Pin synchronisers (third stage for edge detection and for aligning chip select, address and data with the write)
  logic [1:0] cs_s_q, rd_s_q, wr_s_q;
  logic       wr_s3_q, cs_s3_q;
  logic [6:0] addr_s1_q, addr_s2_q, addr_s3_q;
  logic [7:0] din_s1_q, din_s2_q, din_s3_q;
  logic [1:0] tx_line_clock_s_q, ser_s_q, link_s_q;
  logic       tx_line_clock_s3_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s_q    <= 2'h3;
      rd_s_q    <= 2'h3;
      wr_s_q    <= 2'h3;
      wr_s3_q   <= 1'b1;
      cs_s3_q   <= 1'b1;
      addr_s1_q <= 7'h00;
      addr_s2_q <= 7'h00;
      addr_s3_q <= 7'h00;
      din_s1_q  <= 8'h00;
      din_s2_q  <= 8'h00;
      din_s3_q  <= 8'h00;
      tx_line_clock_s_q  <= 2'h0;
      tx_line_clock_s3_q <= 1'b0;
      ser_s_q   <= 2'h0;
      link_s_q  <= 2'h0;
    end else begin
      cs_s_q    <= {cs_s_q[0], cs_b_i};
      rd_s_q    <= {rd_s_q[0], rd_b_i};
      wr_s_q    <= {wr_s_q[0], wr_b_i};
      wr_s3_q   <= wr_s_q[1];
      cs_s3_q   <= cs_s_q[1];
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
      addr_s3_q <= addr_s2_q;
      din_s1_q  <= data_i;
      din_s2_q  <= din_s1_q;
      din_s3_q  <= din_s2_q;
      tx_line_clock_s_q  <= {tx_line_clock_s_q[0], tx_line_clock};
      tx_line_clock_s3_q <= tx_line_clock_s_q[1];
      ser_s_q   <= {ser_s_q[0], tx_serial_in};
      link_s_q  <= {link_s_q[0], ext_link_pin_i};
    end
  end

  // ==========================================================
  // Register file
  // Write lands at the end of the strobe, while address and data are still held
  logic       wr_take;
  logic [7:0] rx_one_q, rx_two_q, tx_one_q, tx_two_q;

  assign wr_take = wr_s_q[1] & ~wr_s3_q & ~cs_s3_q;

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_one_q <= tfc_pkg::RX_CTRL_ONE_RST;
      rx_two_q <= tfc_pkg::RX_CTRL_TWO_RST;
      tx_one_q <= tfc_pkg::TX_CTRL_ONE_RST;
      tx_two_q <= tfc_pkg::TX_CTRL_TWO_RST;
    end else if (wr_take) begin
      case (addr_s3_q)
        tfc_pkg::RX_CTRL_ONE_ADDR: rx_one_q <= din_s3_q; // RULE_17
        tfc_pkg::RX_CTRL_TWO_ADDR: rx_two_q <= din_s3_q; // RULE_17
        tfc_pkg::TX_CTRL_ONE_ADDR: tx_one_q <= din_s3_q; // RULE_17
        tfc_pkg::TX_CTRL_TWO_ADDR: tx_two_q <= din_s3_q; // RULE_17
        default: ;
      endcase
    end
  end

  logic [1:0] test_mode;
  logic       rd_active;
  logic [7:0] rdata_d, rdata_q;
  logic       rd_oe_q;

  assign test_mode = {tx_two_q[tfc_pkg::PIN_TEST_HI_BIT], tx_two_q[tfc_pkg::PIN_TEST_LO_BIT]};
  assign rd_active = ~cs_s_q[1] & ~rd_s_q[1];

  always_comb begin
    case (addr_s2_q)
      tfc_pkg::RX_CTRL_ONE_ADDR: rdata_d = rx_one_q; // RULE_17
      tfc_pkg::RX_CTRL_TWO_ADDR: rdata_d = rx_two_q; // RULE_17
      tfc_pkg::TX_CTRL_ONE_ADDR: rdata_d = tx_one_q; // RULE_17
      tfc_pkg::TX_CTRL_TWO_ADDR: rdata_d = tx_two_q; // RULE_17
      default:                   rdata_d = tfc_pkg::UNMAPPED_RDATA;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rd_oe_q <= rd_active;
    end
  end

  assign data_o    = rdata_q;
  // High-Z test mode also releases the parallel port
  assign data_oe_o = rd_oe_q & (test_mode != tfc_pkg::PIN_TEST_HIZ); // RULE_15

  // ==========================================================
  // Receive resync and loss of frame
  logic       resync_prev_q;
  logic       forced_resync;
  logic       auto_resync;
  logic [5:0] err_win_q;
  logic [5:0] err_win_d;
  logic [2:0] err_cnt;
  logic [2:0] win_len;

  assign forced_resync = rx_one_q[tfc_pkg::FORCE_RESYNC_BIT] & ~resync_prev_q; // RULE_16
  assign auto_resync   = ~rx_one_q[tfc_pkg::AUTO_RESYNC_OFF_BIT] &
                         (oof_event_i |
                          (carrier_loss_i & ~rx_one_q[tfc_pkg::AUTO_RESYNC_SEL_BIT])); // RULE_01
  assign err_win_d     = {err_win_q[4:0], fbit_error_i};
  // Window of 4, 5 or 6 framing bits by the two select bits
  assign win_len = rx_one_q[tfc_pkg::LOF_SELECT_B_BIT] ? 3'h6 :
                   (rx_one_q[tfc_pkg::LOF_SELECT_A_BIT] ? 3'h5 : 3'h4); // RULE_02

  always_comb begin
    err_cnt = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (i < int'(win_len)) begin
        err_cnt = err_cnt + {2'h0, err_win_d[i]};
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      resync_prev_q   <= 1'b0;
      resync_start_o  <= 1'b0;
    end else begin
      resync_prev_q  <= rx_one_q[tfc_pkg::FORCE_RESYNC_BIT];
      resync_start_o <= forced_resync | auto_resync | loss_of_frame_o; // RULE_01 RULE_16
    end
  end

  // Window restarts after each declaration so one error burst reports once
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_win_q       <= 6'h00;
      loss_of_frame_o <= 1'b0;
    end else if (fbit_valid_i) begin
      loss_of_frame_o <= (err_cnt >= 3'(tfc_pkg::LOF_ERR_LIMIT)); // RULE_02
      err_win_q       <= (err_cnt >= 3'(tfc_pkg::LOF_ERR_LIMIT)) ? 6'h00 : err_win_d;
    end else begin
      loss_of_frame_o <= 1'b0;
    end
  end

  assign sync_cross_couple_o = rx_one_q[tfc_pkg::SYNC_CRITERIA_BIT]; // RULE_03 RULE_04
  assign sync_time_long_o    = rx_one_q[tfc_pkg::SYNC_TIME_BIT];

  // ==========================================================
  // Transmit clock loss and fallback
  logic [15:0] idle_cnt_q;
  logic        tx_line_clock_edge;
  logic        tx_line_clock_lost;

  assign tx_line_clock_edge = tx_line_clock_s_q[1] ^ tx_line_clock_s3_q;
  assign tx_line_clock_lost = (idle_cnt_q >= 16'(CLK_LOSS_CYCLES));

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idle_cnt_q <= 16'h0000;
    end else if (tx_line_clock_edge) begin
      idle_cnt_q <= 16'h0000;
    end else if (!tx_line_clock_lost) begin
      idle_cnt_q <= idle_cnt_q + 16'h0001;
    end
  end

  assign tx_use_rx_clock_o = tx_one_q[tfc_pkg::TX_CLK_FALLBACK_BIT] & tx_line_clock_lost; // RULE_05

  // ==========================================================
  // Transmit bit sourcing and channel controls
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      framing_bit_o <= 1'b0;
      crc_bit_o     <= 1'b0;
      link_bit_o    <= 1'b0;
    end else begin
      framing_bit_o <= (tx_one_q[tfc_pkg::FRAMING_PASS_BIT] & fbit_time_i) ?
                       ser_s_q[1] : int_framing_bit_i; // RULE_06
      crc_bit_o     <= (tx_one_q[tfc_pkg::CRC_PASS_BIT] & fbit_time_i) ?
                       ser_s_q[1] : int_crc_bit_i; // RULE_07
      link_bit_o    <= tx_one_q[tfc_pkg::LINK_SRC_SEL_BIT] ?
                       link_s_q[1] : link_reg_bit_i; // RULE_10
    end
  end

  assign chan_sig_insert_o  = tx_one_q[tfc_pkg::ROBBED_SIG_EN_BIT] & ~chan_transparent_i; // RULE_08
  assign chan_bit7_stuff_o  = tx_two_q[tfc_pkg::SEVENTH_STUFF_EN_BIT] & chan_all_zero_i &
                              (tx_one_q[tfc_pkg::GLOBAL_STUFF_BIT] | ~chan_transparent_i); // RULE_09
  assign yellow_bit2_zero_o = tx_one_q[tfc_pkg::YELLOW_ALARM_BIT] &
                              ~tx_two_q[tfc_pkg::SF_YELLOW_FORM_BIT]; // RULE_12 RULE_13
  assign yellow_sbit_one_o  = tx_one_q[tfc_pkg::YELLOW_ALARM_BIT] &
                              tx_two_q[tfc_pkg::SF_YELLOW_FORM_BIT] &
                              (frame_number_i == tfc_pkg::YELLOW_SBIT_FRAME); // RULE_12 RULE_13

  // ==========================================================
  // Line outputs and sync pulse, with pin test modes on top
  logic pos_d, neg_d, sync_d;

  always_comb begin
    pos_d  = tx_one_q[tfc_pkg::BLUE_ALARM_BIT] | data_pos_i; // RULE_11
    neg_d  = tx_one_q[tfc_pkg::BLUE_ALARM_BIT] | data_neg_i; // RULE_11
    sync_d = tx_two_q[tfc_pkg::TX_SYNC_MODE_BIT] ? multiframe_start_i : frame_start_i; // RULE_14
    case (test_mode)
      tfc_pkg::PIN_TEST_LOW: begin // RULE_15
        pos_d  = 1'b0;
        neg_d  = 1'b0;
        sync_d = 1'b0;
      end
      tfc_pkg::PIN_TEST_HIGH: begin // RULE_15
        pos_d  = 1'b1;
        neg_d  = 1'b1;
        sync_d = 1'b1;
      end
      default: ;
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_line_positive_out <= 1'b0;
      tx_line_negative_out <= 1'b0;
      tx_sync_pulse        <= 1'b0;
    end else begin
      tx_line_positive_out <= pos_d;
      tx_line_negative_out <= neg_d;
      tx_sync_pulse        <= sync_d;
    end
  end

  assign line_oe_o = (test_mode != tfc_pkg::PIN_TEST_HIZ); // RULE_15

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_clk_silent;
    !tx_line_clock_edge [*8];
  endsequence

  sequence s_resync_rise;
    !rx_one_q[tfc_pkg::FORCE_RESYNC_BIT] ##1 rx_one_q[tfc_pkg::FORCE_RESYNC_BIT];
  endsequence

  AST_AUTO_RESYNC: assert property ( // RULE_01
    (carrier_loss_i && !rx_one_q[tfc_pkg::AUTO_RESYNC_SEL_BIT] &&
     !rx_one_q[tfc_pkg::AUTO_RESYNC_OFF_BIT]) |=> resync_start_o)
    else $error("carrier loss did not start resync");
  AST_LOF_TWO_OF_FOUR: assert property ( // RULE_02
    (fbit_valid_i && win_len == 3'h4 && err_cnt >= 3'h2) |=> loss_of_frame_o)
    else $error("loss of frame not declared");
  AST_NO_LOF_ONE_ERR: assert property ( // RULE_02
    (fbit_valid_i && err_cnt < 3'h2) |=> !loss_of_frame_o)
    else $error("loss of frame with fewer than two errors");
  AST_FALLBACK: assert property ( // RULE_05
    tx_use_rx_clock_o |-> (tx_one_q[tfc_pkg::TX_CLK_FALLBACK_BIT] && !$past(tx_line_clock_edge)))
    else $error("clock fallback without silent clock");
  // Loss limit sits above eight cycles, so a short gap never falls back
  AST_FALLBACK_QUIET: assert property ( // RULE_05
    (tx_line_clock_edge ##1 s_clk_silent) |-> !tx_use_rx_clock_o)
    else $error("clock fallback after short gap");
  AST_FALLBACK_HOLD: assert property ( // RULE_05
    tx_line_clock_edge |=> !tx_use_rx_clock_o)
    else $error("fallback kept after clock edge");
  AST_FRAMING_SRC: assert property ( // RULE_06
    (tx_one_q[tfc_pkg::FRAMING_PASS_BIT] && fbit_time_i) |=> framing_bit_o == $past(ser_s_q[1]))
    else $error("framing bit not from serial input");
  AST_CRC_SRC: assert property ( // RULE_07
    (!tx_one_q[tfc_pkg::CRC_PASS_BIT]) |=> crc_bit_o == $past(int_crc_bit_i))
    else $error("crc bit not internal");
  AST_LINK_SRC: assert property ( // RULE_10
    (!tx_one_q[tfc_pkg::LINK_SRC_SEL_BIT]) |=> link_bit_o == $past(link_reg_bit_i))
    else $error("link bit not from register");
  AST_BLUE: assert property ( // RULE_11
    (tx_one_q[tfc_pkg::BLUE_ALARM_BIT] && test_mode == tfc_pkg::PIN_TEST_NORMAL)
    |=> (tx_line_positive_out && tx_line_negative_out))
    else $error("blue alarm not all ones");
  AST_SYNC_MODE: assert property ( // RULE_14
    (tx_two_q[tfc_pkg::TX_SYNC_MODE_BIT] && test_mode == tfc_pkg::PIN_TEST_NORMAL)
    |=> tx_sync_pulse == $past(multiframe_start_i))
    else $error("sync pulse not on multiframe");
  AST_TEST_LOW: assert property ( // RULE_15
    (test_mode == tfc_pkg::PIN_TEST_LOW) |=> (!tx_line_positive_out && !tx_sync_pulse))
    else $error("test low not driving low");
  AST_FORCED_ONCE: assert property ( // RULE_16
    s_resync_rise |=> resync_start_o)
    else $error("resync edge did not start resync");
  AST_READBACK: assert property ( // RULE_17
    (wr_take && addr_s3_q == tfc_pkg::TX_CTRL_ONE_ADDR) |=> tx_one_q == $past(din_s3_q))
    else $error("register did not store write");
endmodule

//--- design/tfc_pkg.sv
// Constants of the framer receive and transmit control register bank
package tfc_pkg;
  // ==========================================================
  // Register offsets on the parallel port
  localparam logic [6:0] RX_CTRL_ONE_ADDR = 7'h2B;
  localparam logic [6:0] RX_CTRL_TWO_ADDR = 7'h2C;
  localparam logic [6:0] TX_CTRL_ONE_ADDR = 7'h35;
  localparam logic [6:0] TX_CTRL_TWO_ADDR = 7'h36;
  // ==========================================================
  // Reset values and unmapped read data
  localparam logic [7:0] RX_CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] RX_CTRL_TWO_RST  = 8'h00;
  localparam logic [7:0] TX_CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] TX_CTRL_TWO_RST  = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA   = 8'h00;
  // ==========================================================
  // Field positions, receive control one
  localparam int AUTO_RESYNC_SEL_BIT   = 6;
  localparam int LOF_SELECT_A_BIT      = 5;
  localparam int LOF_SELECT_B_BIT      = 4;
  localparam int SYNC_CRITERIA_BIT     = 3;
  localparam int SYNC_TIME_BIT         = 2;
  localparam int AUTO_RESYNC_OFF_BIT   = 1;
  localparam int FORCE_RESYNC_BIT      = 0;
  // Field positions, transmit control one
  localparam int TX_CLK_FALLBACK_BIT   = 7;
  localparam int FRAMING_PASS_BIT      = 6;
  localparam int CRC_PASS_BIT          = 5;
  localparam int ROBBED_SIG_EN_BIT     = 4;
  localparam int GLOBAL_STUFF_BIT      = 3;
  localparam int LINK_SRC_SEL_BIT      = 2;
  localparam int BLUE_ALARM_BIT        = 1;
  localparam int YELLOW_ALARM_BIT      = 0;
  // Field positions, transmit control two
  localparam int PIN_TEST_HI_BIT       = 7;
  localparam int PIN_TEST_LO_BIT       = 6;
  localparam int TX_SYNC_MODE_BIT      = 3;
  localparam int SF_YELLOW_FORM_BIT    = 1;
  localparam int SEVENTH_STUFF_EN_BIT  = 0;
  // ==========================================================
  // Pin test mode codes
  localparam logic [1:0] PIN_TEST_NORMAL = 2'h0;
  localparam logic [1:0] PIN_TEST_HIZ    = 2'h1;
  localparam logic [1:0] PIN_TEST_LOW    = 2'h2;
  localparam logic [1:0] PIN_TEST_HIGH   = 2'h3;
  // ==========================================================
  // Framing and timing
  localparam logic [3:0] YELLOW_SBIT_FRAME = 4'hC;
  localparam int         LOF_ERR_LIMIT     = 2;
  localparam int         CLK_PERIOD_NS     = 20;
  localparam int         CLK_LOSS_NS       = 1000;
  localparam int         CLK_LOSS_CYC      = (CLK_LOSS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

//--- testbench/tfc_ctrl_regs_tb.sv
// Self-checking bench of the framer control register bank
module tfc_ctrl_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i, rst_b_i, cs_b_i, rd_b_i, wr_b_i, oof_event_i, carrier_loss_i;
  logic fbit_valid_i, fbit_error_i, tx_line_clock, tx_serial_in, ext_link_pin_i;
  logic fbit_time_i, int_framing_bit_i, int_crc_bit_i, link_reg_bit_i;
  logic chan_transparent_i, chan_all_zero_i, frame_start_i, multiframe_start_i;
  logic data_pos_i, data_neg_i, data_oe_o, resync_start_o, loss_of_frame_o;
  logic sync_cross_couple_o, sync_time_long_o, tx_use_rx_clock_o, framing_bit_o;
  logic crc_bit_o, link_bit_o, chan_sig_insert_o, chan_bit7_stuff_o;
  logic yellow_bit2_zero_o, yellow_sbit_one_o, tx_line_positive_out;
  logic tx_line_negative_out, tx_sync_pulse, line_oe_o, tx_line_clock_run;
  logic [6:0] addr_i;
  logic [7:0] data_i, data_o;
  logic [3:0] frame_number_i;
  int         miscompares, tests_run, rs_cnt, lof_cnt;

  tfc_ctrl_regs #(.CLK_LOSS_CYCLES(16)) dut (
    .clock_i, .rst_b_i, .cs_b_i, .rd_b_i, .wr_b_i, .addr_i, .data_i, .data_o,
    .data_oe_o, .oof_event_i, .carrier_loss_i, .fbit_valid_i, .fbit_error_i,
    .resync_start_o, .loss_of_frame_o, .sync_cross_couple_o, .sync_time_long_o,
    .tx_line_clock, .tx_use_rx_clock_o, .tx_serial_in, .ext_link_pin_i,
    .fbit_time_i, .int_framing_bit_i, .int_crc_bit_i, .link_reg_bit_i,
    .framing_bit_o, .crc_bit_o, .link_bit_o, .chan_transparent_i,
    .chan_all_zero_i, .chan_sig_insert_o, .chan_bit7_stuff_o, .yellow_bit2_zero_o,
    .frame_number_i, .yellow_sbit_one_o, .frame_start_i, .multiframe_start_i,
    .data_pos_i, .data_neg_i, .tx_line_positive_out, .tx_line_negative_out,
    .tx_sync_pulse, .line_oe_o);
  tfc_host_model host (.clock_i(clock_i), .data_i(data_o), .data_oe_i(data_oe_o),
    .cs_b_o(cs_b_i), .rd_b_o(rd_b_i), .wr_b_o(wr_b_i), .addr_o(addr_i), .data_o(data_i));

  // ==========================================================
  // Clocks, event counters, watchdog
  always #10 clock_i = ~clock_i;
  // Line clock offset 3 ns so its edges never meet the system clock
  initial begin
    #3;
    forever #80 if (tx_line_clock_run) tx_line_clock = ~tx_line_clock;
  end
  always @(posedge clock_i) begin
    if (resync_start_o === 1'b1) rs_cnt++;
    if (loss_of_frame_o === 1'b1) lof_cnt++;
  end
  initial begin
    #300us;
    miscompares++;
    results();
  end

  // ==========================================================
  // Helpers
  task automatic chk1(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_i);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic ok;
    host.rd(a, d, ok);
    chk1("read enable", 1'b1, ok);
    chk8("read data", e, d);
  endtask
  task automatic wr1(input logic [7:0] d);
    host.wr(tfc_pkg::RX_CTRL_ONE_ADDR, d);
  endtask
  task automatic wt1(input logic [7:0] d);
    host.wr(tfc_pkg::TX_CTRL_ONE_ADDR, d);
  endtask
  task automatic wt2(input logic [7:0] d);
    host.wr(tfc_pkg::TX_CTRL_TWO_ADDR, d);
  endtask
  task automatic fbit(input logic e);
    @(posedge clock_i);
    fbit_valid_i <= 1'b1;
    fbit_error_i <= e;
    @(posedge clock_i);
    fbit_valid_i <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [6:0] ad [4];
    logic [7:0] rv [4];
    logic [7:0] vl [4];
    ad = '{tfc_pkg::RX_CTRL_ONE_ADDR, tfc_pkg::RX_CTRL_TWO_ADDR,
           tfc_pkg::TX_CTRL_ONE_ADDR, tfc_pkg::TX_CTRL_TWO_ADDR};
    rv = '{tfc_pkg::RX_CTRL_ONE_RST, tfc_pkg::RX_CTRL_TWO_RST,
           tfc_pkg::TX_CTRL_ONE_RST, tfc_pkg::TX_CTRL_TWO_RST};
    vl = '{8'h5A, 8'hC3, 8'h3C, 8'h2D};
    for (int i = 0; i < 4; i++) begin
      rdchk(ad[i], rv[i]);
      host.wr(ad[i], vl[i]);
      rdchk(ad[i], vl[i]);
    end
    host.wr(7'h40, 8'hFF);
    rdchk(7'h40, tfc_pkg::UNMAPPED_RDATA);
  endtask
  task automatic t_resync();
    int r0;
    wr1(8'h02);
    r0 = rs_cnt;
    wr1(8'h03);
    wr1(8'h03);
    chk8("forced resync count", 8'(r0 + 1), 8'(rs_cnt));
    wr1(8'h02);
    wr1(8'h03);
    chk8("forced resync count", 8'(r0 + 2), 8'(rs_cnt));
  endtask
  task automatic t_auto();
    int r0;
    wr1(8'h00);
    r0 = rs_cnt;
    carrier_loss_i <= 1'b1;
    cyc(1);
    carrier_loss_i <= 1'b0;
    cyc(3);
    chk8("carrier loss resync", 8'(r0 + 1), 8'(rs_cnt));
    wr1(8'h40);
    carrier_loss_i <= 1'b1;
    cyc(1);
    carrier_loss_i <= 1'b0;
    oof_event_i <= 1'b1;
    cyc(1);
    oof_event_i <= 1'b0;
    cyc(3);
    chk8("out of frame resync", 8'(r0 + 2), 8'(rs_cnt));
  endtask
  task automatic t_lof();
    int l0;
    wr1(8'h02);
    l0 = lof_cnt;
    fbit(1'b1);
    fbit(1'b0);
    fbit(1'b0);
    fbit(1'b1);
    cyc(3);
    chk8("two of four", 8'(l0 + 1), 8'(lof_cnt));
    fbit(1'b1);
    for (int i = 0; i < 3; i++) fbit(1'b0);
    fbit(1'b1);
    cyc(3);
    chk8("errors five apart", 8'(l0 + 1), 8'(lof_cnt));
  endtask
  task automatic t_sync();
    wr1(8'h02);
    chk1("sequential search", 1'b0, sync_cross_couple_o);
    chk1("sync time short", 1'b0, sync_time_long_o);
    wr1(8'h0E);
    chk1("cross coupled search", 1'b1, sync_cross_couple_o);
    chk1("sync time long", 1'b1, sync_time_long_o);
  endtask
  task automatic t_passthru();
    for (int i = 0; i < 2; i++) begin
      wt1(i[0] ? 8'h64 : 8'h00);
      chk1("framing bit", i[0], framing_bit_o);
      chk1("crc bit", i[0], crc_bit_o);
      chk1("link bit", i[0], link_bit_o);
    end
  endtask
  task automatic t_chan();
    wt2(8'h01);
    wt1(8'h10);
    chk1("signalling open", 1'b1, chan_sig_insert_o);
    chk1("stuff open", 1'b1, chan_bit7_stuff_o);
    chan_transparent_i <= 1'b1;
    cyc(2);
    chk1("signalling blocked", 1'b0, chan_sig_insert_o);
    chk1("stuff blocked", 1'b0, chan_bit7_stuff_o);
    wt1(8'h08);
    chk1("signalling off", 1'b0, chan_sig_insert_o);
    chk1("global stuff", 1'b1, chan_bit7_stuff_o);
    chan_all_zero_i <= 1'b0;
    cyc(2);
    chk1("nonzero channel", 1'b0, chan_bit7_stuff_o);
  endtask
  task automatic t_yellow();
    wt2(8'h00);
    wt1(8'h01);
    frame_number_i <= tfc_pkg::YELLOW_SBIT_FRAME;
    cyc(2);
    chk1("bit two form", 1'b1, yellow_bit2_zero_o);
    chk1("no s bit form", 1'b0, yellow_sbit_one_o);
    wt2(8'h02);
    chk1("s bit form", 1'b1, yellow_sbit_one_o);
    chk1("bit two off", 1'b0, yellow_bit2_zero_o);
    frame_number_i <= 4'hB;
    cyc(2);
    chk1("other frame", 1'b0, yellow_sbit_one_o);
    frame_number_i <= tfc_pkg::YELLOW_SBIT_FRAME;
    wt1(8'h00);
    chk1("yellow off", 1'b0, yellow_sbit_one_o);
  endtask
  task automatic t_tx_sync_pulse();
    frame_start_i <= 1'b1;
    wt2(8'h00);
    chk1("frame mode", 1'b1, tx_sync_pulse);
    wt2(8'h08);
    chk1("multiframe ignores frame", 1'b0, tx_sync_pulse);
    frame_start_i <= 1'b0;
    multiframe_start_i <= 1'b1;
    cyc(3);
    chk1("multiframe mode", 1'b1, tx_sync_pulse);
  endtask
  task automatic t_line();
    logic [7:0] d;
    logic       ok;
    wt2(8'h00);
    wt1(8'h00);
    chk1("normal positive", 1'b1, tx_line_positive_out);
    chk1("normal negative", 1'b0, tx_line_negative_out);
    wt1(8'h02);
    chk1("blue negative", 1'b1, tx_line_negative_out);
    data_pos_i <= 1'b0;
    cyc(3);
    chk1("blue positive", 1'b1, tx_line_positive_out);
    wt1(8'h00);
    wt2(8'hC0);
    chk1("forced high", 1'b1, tx_line_negative_out);
    data_neg_i <= 1'b0;
    data_pos_i <= 1'b1;
    wt2(8'h80);
    chk1("forced low", 1'b0, tx_line_positive_out);
    wt2(8'h40);
    chk1("tristate", 1'b0, line_oe_o);
    host.rd(tfc_pkg::TX_CTRL_TWO_ADDR, d, ok);
    chk1("port tristate", 1'b0, ok);
    wt2(8'h00);
    chk1("driving", 1'b1, line_oe_o);
  endtask
  task automatic t_clk();
    wt1(8'h80);
    chk1("clock present", 1'b0, tx_use_rx_clock_o);
    tx_line_clock_run = 1'b0;
    cyc(30);
    chk1("clock lost", 1'b1, tx_use_rx_clock_o);
    tx_line_clock_run = 1'b1;
    cyc(12);
    chk1("clock back", 1'b0, tx_use_rx_clock_o);
    tx_line_clock_run = 1'b0;
    wt1(8'h00);
    cyc(30);
    chk1("no fallback", 1'b0, tx_use_rx_clock_o);
    tx_line_clock_run = 1'b1;
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    {clock_i, rst_b_i, oof_event_i, carrier_loss_i, fbit_valid_i} = '0;
    {fbit_error_i, tx_line_clock, int_framing_bit_i, int_crc_bit_i} = '0;
    {link_reg_bit_i, chan_transparent_i, frame_start_i, multiframe_start_i} = '0;
    {data_neg_i, miscompares, tests_run, rs_cnt, lof_cnt} = '0;
    {tx_serial_in, ext_link_pin_i, fbit_time_i, chan_all_zero_i} = '1;
    {data_pos_i, tx_line_clock_run} = '1;
    frame_number_i = 4'h0;
    cyc(12);
    rst_b_i <= 1'b1;
    cyc(2);
    t_regs();
    t_resync();
    t_auto();
    t_lof();
    t_sync();
    t_passthru();
    t_chan();
    t_yellow();
    t_tx_sync_pulse();
    t_line();
    t_clk();
    results();
  end
endmodule

//--- testbench/tfc_host_model.sv
// Host processor model on the parallel control port
module tfc_host_model (
  input  wire logic       clock_i,
  input  wire logic [7:0] data_i,
  input  wire logic       data_oe_i,
  output logic            cs_b_o,
  output logic            rd_b_o,
  output logic            wr_b_o,
  output logic      [6:0] addr_o,
  output logic      [7:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_b_o = 1'b1;
    rd_b_o = 1'b1;
    wr_b_o = 1'b1;
    addr_o = 7'h00;
    data_o = 8'h00;
  end
  // ==========================================================
  // Bus cycles
  // Write strobe low 6 cycles, chip select 10, over the 4-cycle minimum of the synchronisers
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clock_i);
    addr_o <= a;
    data_o <= d;
    cs_b_o <= 1'b0;
    wr_b_o <= 1'b0;
    repeat (6) @(posedge clock_i);
    wr_b_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    cs_b_o <= 1'b1;
    // Released lines show the inverse, not a stale value
    data_o <= ~d;
    addr_o <= ~a;
    repeat (5) @(posedge clock_i);
  endtask
  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
    ok = 1'b0;
    d = 8'h00;
    @(posedge clock_i);
    addr_o <= a;
    cs_b_o <= 1'b0;
    rd_b_o <= 1'b0;
    repeat (3) @(posedge clock_i);
    for (int n = 0; n < 8 && !ok; n++) begin
      @(posedge clock_i);
      if (data_oe_i === 1'b1) begin
        ok = 1'b1;
        d = data_i;
      end
    end
    rd_b_o <= 1'b1;
    cs_b_o <= 1'b1;
    addr_o <= ~a;
    repeat (6) @(posedge clock_i);
  endtask
endmodule
